// ==== logic/pmc_params.svh ====
// constants of the power mode controller: offsets, field positions,
// reset values and warm-up counts; included by pmc_top only
//
// Functional notes
// - slow fast-off mode stops fast oscillator; CPU and peripherals run slow.
// - fast oscillator enable bit switches between the two slow modes.
// - in slow or sleep modes divider stages one to six are gated.
// - fast dual idle halts CPU and watchdog, returns to fast dual.
// - sleep fast-off halts CPU, watchdog, fast oscillator; returns to slow.
// - sleep from slow both-oscillator mode keeps the fast oscillator running.
// - peripheral clock halt from slow mode enters tick-only sleep.
// - falling edge of selected tick source ends tick-only sleep in slow fast-off mode, tick-only idle in fast single.
// - tick interrupt needs master, tick enable and tick timer enable all 1.
// - tick release after entry with tick timer enabled sets tick interrupt latch.
// - STOP turns oscillators off and freezes all state; the clock mode and tick control registers still take bus writes in STOP.
// - stop pin releases STOP; execution continues after warm-up.
// - release select 0 means edge release, 1 means level release.
// - return select 0 returns to fast mode, 1 to slow fast-off.
// - port hold 0 makes outputs high impedance in STOP, 1 keeps them.
// - two-bit warm-up field picks one of four warm-up lengths.
// - reset during STOP returns to fast single mode.
// - low two bits of stop control read as zero.
// - STOP with port hold 0 forces port inputs to zero.
// - wake pin port goes high impedance in STOP regardless of hold.
// - writing one to bit 7 of stop control starts STOP.
// - leaving tick-only modes clears the peripheral clock halt bit.
// - leaving idle or sleep clears the CPU halt bit.
// - illegal oscillator enable combinations request a reset.
`ifndef PMC_PARAMS_SVH
`define PMC_PARAMS_SVH

`define PMC_STOP_CTRL_OFS 8'h38
`define PMC_CLK_MODE_OFS  8'h3C
`define PMC_TICK_CTRL_OFS 8'h40
`define PMC_STATUS_OFS    8'h44

`define PMC_STOP_CTRL_RST 8'h00
`define PMC_CLK_MODE_RST  8'h80
`define PMC_TICK_CTRL_RST 8'h00

`define PMC_B_STOP   7
`define PMC_B_STOP_RELEASE_SELECT   6
`define PMC_B_STOP_RETURN_SELECT   5
`define PMC_B_HOLD   4
`define PMC_B_FEN    7
`define PMC_B_SEN    6
`define PMC_B_SEL    5
`define PMC_B_IDLE   4
`define PMC_B_TGH    2
`define PMC_B_TEN    7
`define PMC_B_MIE    6
`define PMC_B_TIE    5
`define PMC_B_TLAT   16

`define PMC_WU_FC0 196608
`define PMC_WU_FC1 65536
`define PMC_WU_FC2 49152
`define PMC_WU_FC3 16384
`define PMC_WU_FS0 24576
`define PMC_WU_FS1 8192
`define PMC_WU_FS2 192
`define PMC_WU_FS3 64

`endif

// ==== logic/pmc_pkg.sv ====
// types of the power mode controller
// assumes nothing of its surroundings
package pmc_pkg;

	typedef enum logic [11:0] {
		pmc_fast_single = 12'h001,
		pmc_fast_dual   = 12'h002,
		pmc_slow_both   = 12'h004,
		pmc_slow_foff   = 12'h008,
		pmc_idle_fs     = 12'h010,
		pmc_idle_fd     = 12'h020,
		pmc_tick_idle   = 12'h040,
		pmc_tick_sleep  = 12'h080,
		pmc_sleep_foff  = 12'h100,
		pmc_sleep_both  = 12'h200,
		pmc_stop        = 12'h400,
		pmc_warm        = 12'h800
	} pmc_mode_e;

	typedef struct packed {
		logic fast_osc_on;
		logic slow_osc_on;
		logic main_slow;
		logic cpu_run;
		logic wdt_run;
		logic periph_clk_en;
		logic tick_clk_en;
		logic div_low_en;
		logic div_clear;
	} pmc_clk_s;

	typedef struct packed {
		logic ports_hiz;
		logic port_in_zero;
		logic wake_pin_hiz;
	} pmc_port_s;

endpackage

// ==== logic/pmc_top.sv ====
// power mode controller: run, idle, sleep, tick-only and STOP modes
// assumes a classic Wishbone master on sys_clk; wake_pin is asynchronous,
// wake_req, tick_src, fc_pulse and fs_pulse come from sys_clk logic
`timescale 1ns/10ps
`include "pmc_params.svh"

module pmc_top
	import pmc_pkg::*;
#(
	parameter int unsigned WU_FC0 = `PMC_WU_FC0,
	parameter int unsigned WU_FC1 = `PMC_WU_FC1,
	parameter int unsigned WU_FC2 = `PMC_WU_FC2,
	parameter int unsigned WU_FC3 = `PMC_WU_FC3,
	parameter int unsigned WU_FS0 = `PMC_WU_FS0,
	parameter int unsigned WU_FS1 = `PMC_WU_FS1,
	parameter int unsigned WU_FS2 = `PMC_WU_FS2,
	parameter int unsigned WU_FS3 = `PMC_WU_FS3
)
(
	input  wire logic        sys_clk,
	input  wire logic        srst,
	input  wire logic        cyc_i,
	input  wire logic        stb_i,
	input  wire logic        we_i,
	input  wire logic [7:0]  adr_i,
	input  wire logic [3:0]  sel_i,
	input  wire logic [31:0] dat_i,
	output logic      [31:0] dat_o,
	output logic             ack_o,
	input  wire logic        wake_pin,
	input  wire logic        wake_req,
	input  wire logic [7:0]  tick_src,
	input  wire logic        fc_pulse,
	input  wire logic        fs_pulse,
	output pmc_clk_s         clk_o,
	output pmc_port_s        port_o,
	output logic             tick_irq,
	output logic             osc_fault_rst
);

	// ----------------------------------------
	// functions
	// ----------------------------------------
	function automatic pmc_mode_e run_sel(
		input logic fen,
		input logic sen,
		input logic sel
	);
		if (sel)
			run_sel = fen ? pmc_slow_both : pmc_slow_foff;
		else
			run_sel = sen ? pmc_fast_dual : pmc_fast_single;
	endfunction

	function automatic logic [17:0] wu_len(
		input logic [1:0] code,
		input logic       slow
	);
		unique case ({slow, code})
		3'b000: wu_len = 18'(WU_FC0);
		3'b001: wu_len = 18'(WU_FC1);
		3'b010: wu_len = 18'(WU_FC2);
		3'b011: wu_len = 18'(WU_FC3);
		3'b100: wu_len = 18'(WU_FS0);
		3'b101: wu_len = 18'(WU_FS1);
		3'b110: wu_len = 18'(WU_FS2);
		3'b111: wu_len = 18'(WU_FS3);
		endcase
	endfunction

	// ----------------------------------------
	// state
	// ----------------------------------------
	pmc_mode_e   mode_q;
	pmc_mode_e   mode_d;
	logic [7:2]  stop_ctrl_q;
	logic        fen_q;
	logic        sen_q;
	logic        sel_q;
	logic        idle_q;
	logic        tgh_q;
	logic        ten_q;
	logic        mie_q;
	logic        tie_q;
	logic [2:0]  tsrc_q;
	logic        tlat_q;
	logic        ten_ent_q;
	logic        ret_slow_q;
	logic [17:0] wu_cnt_q;
	logic        wp_s1_q;
	logic        wp_s2_q;
	logic        wp_s3_q;
	logic        tick_prev_q;

	// ----------------------------------------
	// wishbone decode
	// ----------------------------------------
	wire req      = cyc_i & stb_i;
	wire wr_take  = req & ack_o & we_i & sel_i[0];
	wire hit_stop = adr_i[7:2] == `PMC_STOP_CTRL_OFS >> 2;
	wire hit_clk  = adr_i[7:2] == `PMC_CLK_MODE_OFS >> 2;
	wire hit_tick = adr_i[7:2] == `PMC_TICK_CTRL_OFS >> 2;
	wire hit_stat = adr_i[7:2] == `PMC_STATUS_OFS >> 2;
	wire wr_stop  = wr_take & hit_stop;
	wire wr_clk   = wr_take & hit_clk;
	wire wr_tick  = wr_take & hit_tick;
	wire wr_stat  = wr_take & hit_stat;

	wire is_run  = mode_q inside {pmc_fast_single, pmc_fast_dual, pmc_slow_both, pmc_slow_foff};
	wire is_slow = mode_q inside {pmc_slow_both, pmc_slow_foff};
	wire is_lowc = is_slow | (mode_q inside {pmc_sleep_foff, pmc_sleep_both, pmc_tick_sleep});
	wire is_halt = mode_q inside {pmc_stop, pmc_warm};
	wire is_idle = mode_q inside {pmc_idle_fs, pmc_idle_fd, pmc_sleep_foff, pmc_sleep_both};
	wire is_tick = mode_q inside {pmc_tick_idle, pmc_tick_sleep};

	// illegal oscillator enables are refused and raise a reset request
	wire nf        = dat_i[`PMC_B_FEN];
	wire ns        = dat_i[`PMC_B_SEN];
	wire osc_fault = wr_clk & ((!nf & !ns) | (!nf & !sel_q) | (ns == 1'b0 & sel_q));

	wire stop_go   = wr_stop & dat_i[`PMC_B_STOP] & is_run;
	wire rel_level = stop_ctrl_q[`PMC_B_STOP_RELEASE_SELECT];
	wire pin_rise  = wp_s2_q & !wp_s3_q;
	// level release cannot enter STOP while the pin already stands high
	wire stop_rel  = rel_level ? wp_s2_q : pin_rise;
	wire tick_cur  = tick_src[tsrc_q];
	wire tick_fall = tick_prev_q & !tick_cur;
	wire tick_rel  = is_tick & tick_fall;
	wire idle_rel  = is_idle & wake_req;
	wire wu_done   = mode_q == pmc_warm && wu_cnt_q == 18'h00000;
	wire wu_step   = ret_slow_q ? fs_pulse : fc_pulse;
	wire ret_slow  = stop_ctrl_q[`PMC_B_STOP_RETURN_SELECT];
	wire hold_out  = stop_ctrl_q[`PMC_B_HOLD];
	wire [3:2] wu_code  = stop_go ? dat_i[3:2] : stop_ctrl_q[3:2];
	wire       ret_next = stop_go ? dat_i[`PMC_B_STOP_RETURN_SELECT] : ret_slow;

	// ----------------------------------------
	// mode sequencing
	// ----------------------------------------
	always_comb
	begin
		mode_d = mode_q;
		unique case (mode_q)
		pmc_fast_single, pmc_fast_dual, pmc_slow_both, pmc_slow_foff:
		begin
			if (stop_go)
				mode_d = (rel_level && wp_s2_q) ? pmc_warm : pmc_stop;
			else if (tgh_q)
				mode_d = is_slow ? pmc_tick_sleep : pmc_tick_idle;
			else if (idle_q)
			begin
				unique case (mode_q)
				pmc_fast_single: mode_d = pmc_idle_fs;
				pmc_fast_dual:   mode_d = pmc_idle_fd;
				pmc_slow_both:   mode_d = pmc_sleep_both;
				default:         mode_d = pmc_sleep_foff;
				endcase
			end
			else
				mode_d = run_sel(fen_q, sen_q, sel_q);
		end
		pmc_idle_fs:    if (idle_rel) mode_d = pmc_fast_single;
		pmc_idle_fd:    if (idle_rel) mode_d = pmc_fast_dual;
		pmc_sleep_foff: if (idle_rel) mode_d = pmc_slow_foff;
		pmc_sleep_both: if (idle_rel) mode_d = pmc_slow_both;
		pmc_tick_idle:  if (tick_rel) mode_d = pmc_fast_single;
		pmc_tick_sleep: if (tick_rel) mode_d = pmc_slow_foff;
		pmc_stop:       if (stop_rel) mode_d = pmc_warm;
		pmc_warm:       if (wu_done)
			mode_d = ret_slow_q ? pmc_slow_foff : run_sel(1'b1, sen_q, 1'b0);
		default:        mode_d = pmc_fast_single;
		endcase
	end

	// reset also ends STOP and lands in fast single mode
	always_ff @(posedge sys_clk)
	begin
		if (srst)
			mode_q <= pmc_fast_single;
		else
			mode_q <= mode_d;
	end

	// ----------------------------------------
	// stop pin synchroniser and edge capture
	// ----------------------------------------
	always_ff @(posedge sys_clk)
	begin
		if (srst)
		begin
			wp_s1_q     <= 1'b0;
			wp_s2_q     <= 1'b0;
			wp_s3_q     <= 1'b0;
			tick_prev_q <= 1'b0;
		end
		else
		begin
			wp_s1_q     <= wake_pin;
			wp_s2_q     <= wp_s1_q;
			wp_s3_q     <= wp_s2_q;
			tick_prev_q <= tick_cur;
		end
	end

	// ----------------------------------------
	// warm-up counter
	// ----------------------------------------
	always_ff @(posedge sys_clk)
	begin
		if (srst)
		begin
			wu_cnt_q   <= 18'h00000;
			ret_slow_q <= 1'b0;
		end
		else if (mode_d == pmc_warm && mode_q != pmc_warm)
		begin
			wu_cnt_q   <= wu_len(wu_code, ret_next) - 18'h00001;
			ret_slow_q <= ret_next;
		end
		else if (mode_q == pmc_warm && wu_step && wu_cnt_q != 18'h00000)
			wu_cnt_q <= wu_cnt_q - 18'h00001;
	end

	// ----------------------------------------
	// registers
	// ----------------------------------------
	always_ff @(posedge sys_clk)
	begin
		if (srst)
			stop_ctrl_q <= 6'(`PMC_STOP_CTRL_RST >> 2);
		else if (wu_done)
			stop_ctrl_q[`PMC_B_STOP] <= 1'b0;
		else if (wr_stop && !is_halt)
			stop_ctrl_q <= dat_i[7:2];
	end

	always_ff @(posedge sys_clk)
	begin
		if (srst)
		begin
			fen_q  <= 1'(`PMC_CLK_MODE_RST >> `PMC_B_FEN);
			sen_q  <= 1'b0;
			sel_q  <= 1'b0;
			idle_q <= 1'b0;
			tgh_q  <= 1'b0;
		end
		else
		begin
			if (wr_clk && !osc_fault)
			begin
				fen_q  <= nf;
				sen_q  <= ns;
				sel_q  <= dat_i[`PMC_B_SEL];
				idle_q <= dat_i[`PMC_B_IDLE];
				tgh_q  <= dat_i[`PMC_B_TGH];
			end
			if (idle_rel)
				idle_q <= 1'b0;
			if (tick_rel)
				tgh_q <= 1'b0;
			if (wu_done && ret_slow_q)
			begin
				sel_q <= 1'b1;
				fen_q <= 1'b0;
			end
			else if (wu_done)
			begin
				sel_q <= 1'b0;
				fen_q <= 1'b1;
			end
		end
	end

	// tick latch: a set in the same cycle as a software clear wins
	always_ff @(posedge sys_clk)
	begin
		if (srst)
		begin
			ten_q     <= 1'b0;
			mie_q     <= 1'b0;
			tie_q     <= 1'b0;
			tsrc_q    <= 3'h0;
			tlat_q    <= 1'b0;
			ten_ent_q <= 1'b0;
		end
		else
		begin
			if (wr_tick)
			begin
				ten_q  <= dat_i[`PMC_B_TEN];
				mie_q  <= dat_i[`PMC_B_MIE];
				tie_q  <= dat_i[`PMC_B_TIE];
				tsrc_q <= dat_i[2:0];
			end
			if (is_run && tgh_q)
				ten_ent_q <= ten_q;
			if (tick_rel && ten_ent_q)
				tlat_q <= 1'b1;
			else if (wr_stat && dat_i[0])
				tlat_q <= 1'b0;
		end
	end

	// ----------------------------------------
	// bus answer: ack one cycle after the request is seen
	// ----------------------------------------
	wire [31:0] rd_stop = {24'h000000, stop_ctrl_q, 2'b00};
	wire [31:0] rd_clk  = {24'h000000, fen_q, sen_q, is_lowc, idle_q, 1'b0,
		tgh_q, 2'b00};
	wire [31:0] rd_tick = {24'h000000, ten_q, mie_q, tie_q, 2'b00, tsrc_q};
	wire [31:0] rd_stat = {15'h0000, tlat_q, 4'h0, mode_q};
	wire [31:0] rd_mux  = hit_stop ? rd_stop : hit_clk ? rd_clk
		: hit_tick ? rd_tick : hit_stat ? rd_stat : 32'h00000000;

	always_ff @(posedge sys_clk)
	begin
		if (srst)
		begin
			ack_o <= 1'b0;
			dat_o <= 32'h00000000;
		end
		else
		begin
			ack_o <= req & !ack_o;
			dat_o <= rd_mux;
		end
	end

	// ----------------------------------------
	// registered outputs
	// ----------------------------------------
	always_ff @(posedge sys_clk)
	begin
		if (srst)
		begin
			clk_o         <= 9'h13E;
			port_o        <= 3'h0;
			tick_irq      <= 1'b0;
			osc_fault_rst <= 1'b0;
		end
		else
		begin
			clk_o.fast_osc_on   <= is_halt ? (mode_q == pmc_warm && !ret_slow_q)
				: (fen_q && mode_q != pmc_sleep_foff);
			clk_o.slow_osc_on   <= is_halt ? (mode_q == pmc_warm && (ret_slow_q
				|| sen_q)) : (sen_q || is_lowc);
			clk_o.main_slow     <= is_lowc;
			clk_o.cpu_run       <= is_run;
			clk_o.wdt_run       <= is_run;
			clk_o.periph_clk_en <= !is_tick && !is_halt;
			clk_o.tick_clk_en   <= !is_halt;
			clk_o.div_low_en    <= !is_lowc && !(mode_q == pmc_stop)
				&& !(mode_q == pmc_warm && ret_slow_q);
			clk_o.div_clear     <= mode_q == pmc_stop;
			port_o.ports_hiz    <= is_halt && !hold_out;
			port_o.port_in_zero <= is_halt && !hold_out;
			port_o.wake_pin_hiz <= is_halt;
			tick_irq            <= tlat_q && mie_q && tie_q && ten_q;
			osc_fault_rst       <= osc_fault;
		end
	end

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (srst);

	a_wake_hiz: assert property (
		mode_q == pmc_stop |=> port_o.wake_pin_hiz)
		else $error("wake pin not released in stop");
	a_idle_clear: assert property (
		idle_rel |=> !idle_q && is_run)
		else $error("halt bit not cleared on wake");
	a_tick_clear: assert property (
		tick_rel |=> !tgh_q ##1 clk_o.periph_clk_en)
		else $error("tick release did not restore clocks");
	a_slow_div: assert property (
		is_lowc |=> !clk_o.div_low_en)
		else $error("low divider runs in slow clock mode");
	a_fault_rst: assert property (
		osc_fault |=> osc_fault_rst && $stable(fen_q))
		else $error("oscillator fault not reported");
	a_tick_irq: assert property (
		tick_irq |-> $past(tlat_q) && $past(mie_q) && $past(ten_q))
		else $error("tick interrupt without enables");
	a_stop_entry: assert property (
		stop_go && !rel_level |=> mode_q == pmc_stop ##1 port_o.wake_pin_hiz)
		else $error("stop not entered");
	a_warm_return: assert property (
		wu_done && ret_slow_q |=> mode_q == pmc_slow_foff ##1 clk_o.main_slow)
		else $error("wrong mode after warm-up");
	a_level_rel: assert property (
		mode_q == pmc_stop && rel_level && wp_s2_q |=> mode_q == pmc_warm)
		else $error("level release missed");

endmodule

// ==== verif/pmc_wake_model.sv ====
// stand-in for the external source of the stop pin
// assumes go is a one-cycle strobe on sys_clk from the bench
`timescale 1ns/10ps

module pmc_wake_model
(
	input  wire logic       sys_clk,
	input  wire logic       go,
	input  wire logic [7:0] dly,
	output logic            wake_pin
);
	logic [7:0] cnt_q = 8'h00;
	logic [2:0] hold_q = 3'h0;

	initial wake_pin = 1'b0;

	// ----
	// pin: rises dly + 1 cycles after go is sampled, falls after a short hold
	// ----
	// the hold outlasts the synchroniser so edge and level release both see it
	always @(posedge sys_clk)
	begin
		if (go)
			cnt_q <= dly + 8'h01;
		else if (cnt_q != 8'h00)
			cnt_q <= cnt_q - 8'h01;
		if (cnt_q == 8'h01)
		begin
			wake_pin <= 1'b1;
			hold_q   <= 3'h6;
		end
		else if (hold_q != 3'h0)
			hold_q <= hold_q - 3'h1;
		else
			wake_pin <= 1'b0;
	end
endmodule

// ==== verif/testbench.sv ====
// self-checking bench of the power mode controller
// assumes pmc_pkg, pmc_top and pmc_wake_model are compiled first
`timescale 1ns/10ps

module testbench;
	import pmc_pkg::*;

	// ----
	// setup
	// ----
	localparam logic [7:0] A_STOP = 8'h38;
	localparam logic [7:0] A_CLK  = 8'h3C;
	localparam logic [7:0] A_TICK = 8'h40;
	localparam logic [7:0] A_STAT = 8'h44;
	// warm-up counts cut short and spread so each select code is told apart
	localparam int WFC [4] = '{64, 24, 40, 8};
	localparam int WFS [4] = '{48, 16, 32, 4};

	logic        sys_clk, srst, cyc_i, stb_i, we_i, ack_o, go;
	logic        wake_pin, wake_req, fc_pulse, fs_pulse, tick_irq, osc_fault_rst;
	logic [7:0]  adr_i, tick_src, dly;
	logic [3:0]  sel_i;
	logic [31:0] dat_i, dat_o, rd;
	pmc_clk_s    clk_o;
	pmc_port_s   port_o;
	int          n_errors = 0;
	int          checks_done = 0;
	int          cyc_cnt = 0;
	int          mclk, mstop, s, w, n, k;

	pmc_top #(
		.WU_FC0(WFC[0]), .WU_FC1(WFC[1]), .WU_FC2(WFC[2]), .WU_FC3(WFC[3]),
		.WU_FS0(WFS[0]), .WU_FS1(WFS[1]), .WU_FS2(WFS[2]), .WU_FS3(WFS[3])
	) dut (
		.sys_clk(sys_clk), .srst(srst), .cyc_i(cyc_i), .stb_i(stb_i),
		.we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
		.dat_o(dat_o), .ack_o(ack_o), .wake_pin(wake_pin), .wake_req(wake_req),
		.tick_src(tick_src), .fc_pulse(fc_pulse), .fs_pulse(fs_pulse),
		.clk_o(clk_o), .port_o(port_o), .tick_irq(tick_irq),
		.osc_fault_rst(osc_fault_rst)
	);

	pmc_wake_model wake (.sys_clk(sys_clk), .go(go), .dly(dly), .wake_pin(wake_pin));

	initial
	begin
		sys_clk = 1'b0;
		forever #10 sys_clk = ~sys_clk;
	end

	// a hang is cut short well beyond the expected run
	always @(posedge sys_clk)
	begin
		cyc_cnt <= cyc_cnt + 1;
		if (cyc_cnt == 20000)
		begin
			n_errors++;
			final_report();
		end
	end

	// ----
	// tasks
	// ----
	task automatic final_report();
		$display("mismatches %0d comparisons %0d", n_errors, checks_done);
		if (n_errors == 0 && checks_done > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checks_done++;
		if (g !== e)
		begin
			n_errors++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask

	// classic single cycle; request held until ack is sampled high
	task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
		int t;
		@(posedge sys_clk);
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i  <= w;
		adr_i <= a;
		dat_i <= {24'h0, d};
		t = 0;
		do
		begin
			@(posedge sys_clk);
			t++;
		end
		while (ack_o !== 1'b1 && t < 20);
		rd = dat_o;
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
		we_i  <= 1'b0;
		chk("ack", 1, {31'h0, ack_o});
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		wb(1'b1, a, d);
		if (a == A_CLK)
			mclk = d;
		if (a == A_STOP)
			mstop = d;
	endtask

	task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] e);
		wb(1'b0, a, 8'h00);
		chk(nm, e, rd);
	endtask

	task automatic mchk(input pmc_mode_e e);
		repeat (2) @(posedge sys_clk);
		wb(1'b0, A_STAT, 8'h00);
		chk("mode", {20'h0, e}, {20'h0, rd[11:0]});
	endtask

	task automatic wake_pulse();
		@(posedge sys_clk);
		wake_req <= 1'b1;
		@(posedge sys_clk);
		wake_req <= 1'b0;
		mclk = mclk & 8'hEB;
	endtask

	// ----
	// main sequence
	// ----
	initial
	begin
		{cyc_i, stb_i, we_i, wake_req, go} = 5'h00;
		{adr_i, tick_src, dly, dat_i} = 56'h0;
		sel_i = 4'h1;
		fc_pulse = 1'b1;
		fs_pulse = 1'b1;
		srst = 1'b1;
		s = $urandom(81);
		repeat (2) @(posedge sys_clk);
		srst <= 1'b0;
		@(posedge sys_clk);
		chk("clk_rst", 32'h13E, {23'h0, clk_o});
		rdchk("stop_rst", A_STOP, 32'h00);
		rdchk("clk_rst", A_CLK, 32'h80);
		mchk(pmc_fast_single);
		wr(8'h50, 8'hFF);
		rdchk("unmapped", 8'h50, 32'h0);
		wr(A_STOP, 8'h7F & $urandom);
		rdchk("stop_rw", A_STOP, mstop & 32'h7C);
		// dual-clock and fast-off run, idle and sleep modes
		wr(A_CLK, 8'hC0);
		mchk(pmc_fast_dual);
		wr(A_CLK, 8'hD0);
		mchk(pmc_idle_fd);
		chk("idle_clk", 32'h18E, {23'h0, clk_o});
		wake_pulse();
		mchk(pmc_fast_dual);
		rdchk("idle_clr", A_CLK, mclk);
		wr(A_CLK, 8'hE0);
		mchk(pmc_slow_both);
		chk("div_low", 0, {31'h0, clk_o.div_low_en});
		wr(A_CLK, 8'hF0);
		mchk(pmc_sleep_both);
		chk("sleep_both_osc_clk", 32'h1CC, {23'h0, clk_o});
		wake_pulse();
		mchk(pmc_slow_both);
		wr(A_CLK, 8'h60);
		mchk(pmc_slow_foff);
		chk("slow_fast_off_mode_clk", 32'h0FC, {23'h0, clk_o});
		wr(A_CLK, 8'h70);
		mchk(pmc_sleep_foff);
		chk("sleep_fast_off_clk", 32'h0CC, {23'h0, clk_o});
		wake_pulse();
		mchk(pmc_slow_foff);
		rdchk("sleep_clr", A_CLK, mclk);
		// tick-only sleep, with the tick timer off then on
		for (k = 0; k < 2; k++)
		begin
			s = $urandom % 8;
			wr(A_TICK, 8'h60 | (k << 7) | s);
			rdchk("tick_reg", A_TICK, 8'h60 | (k << 7) | s);
			tick_src <= 8'hFF;
			wr(A_CLK, 8'h64);
			mchk(pmc_tick_sleep);
			chk("tick_clk", 32'h1, {30'h0, clk_o.periph_clk_en, clk_o.tick_clk_en});
			// other sources falling must not release
			tick_src <= 8'h01 << s;
			mchk(pmc_tick_sleep);
			tick_src <= 8'h00;
			mchk(pmc_slow_foff);
			mclk = 8'h60;
			rdchk("tgh_clr", A_CLK, mclk);
			chk("tick_irq", k, {31'h0, tick_irq});
			wr(A_STAT, 8'h01);
			mchk(pmc_slow_foff);
			chk("irq_clr", 0, {31'h0, tick_irq});
		end
		// stop entry, hold, release, warm-up and return, per select code
		for (k = 0; k < 4; k++)
		begin
			if (k[1])
			begin
				wr(A_CLK, 8'hE0);
				wr(A_CLK, 8'h60);
			end
			else
				wr(A_CLK, 8'hC0);
			dly <= 8'd20;
			// return select matches the starting mode
			wr(A_STOP, 8'h80 | (k[0] << 6) | (k[1] << 5) | ((k[0] ^ k[1]) << 4) | (k << 2));
			go <= 1'b1;
			@(posedge sys_clk);
			go <= 1'b0;
			mchk(pmc_stop);
			chk("stop_clk", 0, {23'h0, clk_o & 9'h1F8});
			chk("ports", {29'h0, ~mstop[4], ~mstop[4], 1'b1}, {29'h0, port_o});
			wb(1'b1, A_STOP, 8'h00);
			n = 0;
			while (wake_pin !== 1'b1 && n < 100)
			begin
				@(posedge sys_clk);
				n++;
			end
			n = 0;
			while (clk_o.cpu_run !== 1'b1 && n < 300)
			begin
				@(posedge sys_clk);
				n++;
			end
			w = k[1] ? WFS[k] : WFC[k];
			chk("warm_len", w, (n >= w + 1 && n <= w + 8) ? w : n);
			mchk(k[1] ? pmc_slow_foff : pmc_fast_dual);
			rdchk("stop_end", A_STOP, mstop & 32'h7C);
			chk("ports_end", 0, {29'h0, port_o});
		end
		// reset during stop lands in fast single mode
		wr(A_STOP, 8'hA0);
		mchk(pmc_stop);
		srst <= 1'b1;
		repeat (2) @(posedge sys_clk);
		srst <= 1'b0;
		mchk(pmc_fast_single);
		rdchk("clk_after", A_CLK, 32'h80);
		wr(A_CLK, 8'h00);
		n = 0;
		repeat (4)
		begin
			@(posedge sys_clk);
			n += osc_fault_rst;
		end
		chk("fault_rst", 1, n);
		mchk(pmc_fast_single);
		// single-clock idle and tick-only idle both come back to fast single mode
		wr(A_CLK, 8'h90);
		mchk(pmc_idle_fs);
		wake_pulse();
		mchk(pmc_fast_single);
		tick_src <= 8'hFF;
		wr(A_CLK, 8'h84);
		mchk(pmc_tick_idle);
		tick_src <= 8'h00;
		mchk(pmc_fast_single);
		rdchk("tick_idle_clr", A_CLK, 32'h80);
		final_report();
	end
endmodule
